// file: hdl/rqn_pkg.sv
// Package of constants and types shared by the rotate and normalize sequencer ends
//
// Overview of operation
// - Start rotates MQ left by counter value
// - Own start command sets rotate-in-progress flip-flop unless count is zero
// - Each pulse rotates MQ, decrements, tests finish
// - Zero count: no pulses, no wait
// - Count one: last rotate, done, clear, resume
// - Nonzero count raises shift-wait at start
// - Controller prerotates accumulator 36 places first
// - Normalize start loads 36, sets flip-flop
// - Each pulse compares bits 34, 35; one path
// - Equal: rotate, decrement or load 71, resume 38
// - Differ: no rotate, clear flip-flop, resume
// - Thirty-seventh pulse rotates and loads 71
// - At 38 without difference: rotate, 37, end
// - Result has sign bit 35, msb bit 34
// - Counter read as size index, 36/0/37
// - Count 38..71 means msb in bits 0..33
package rqn_pkg;

    localparam int MQ_W = 36;
    localparam int ACC_W = 72;
    localparam int CNT_W = 7;
    localparam int DATA_W = 36;
    localparam int ADDR_W = 4;

    localparam int ACC_SIGN_BIT = 35;
    localparam int ACC_MSB_BIT = 34;

    localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;
    localparam logic [CNT_W-1:0] CNT_36 = 7'h24;
    localparam logic [CNT_W-1:0] CNT_38 = 7'h26;
    localparam logic [CNT_W-1:0] CNT_71 = 7'h47;

    localparam logic [MQ_W-1:0] MQ_RESET = 36'h0_0000_0000;
    localparam logic [ACC_W-1:0] ACC_RESET = 72'h00_0000_0000_0000_0000;

    // Controller register offsets
    localparam logic [ADDR_W-1:0] REG_CMD = 4'h0;
    localparam logic [ADDR_W-1:0] REG_COUNT = 4'h1;
    localparam logic [ADDR_W-1:0] REG_MQ = 4'h2;
    localparam logic [ADDR_W-1:0] REG_ACC_LO = 4'h3;
    localparam logic [ADDR_W-1:0] REG_ACC_HI = 4'h4;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h5;

    localparam logic [DATA_W-1:0] CMD_ROTATE_MQ = 36'h0_0000_0001;
    localparam logic [DATA_W-1:0] CMD_NORMALIZE = 36'h0_0000_0002;
    localparam logic [DATA_W-1:0] DATA_ZERO = 36'h0_0000_0000;

    typedef enum logic [2:0] {
        CTL_IDLE = 3'b000,
        CTL_START = 3'b001,
        CTL_CHECK = 3'b010,
        CTL_RUN = 3'b011
    } rqn_ctl_state_type;

    typedef enum logic [1:0] {
        KIND_ROT_MQ = 2'b00,
        KIND_ROT_ACC = 2'b01,
        KIND_NORM = 2'b10
    } rqn_kind_type;

endpackage : rqn_pkg

// file: hdl/rqn_if.sv
// Interface joining the central timing control and the sequencer device
`timescale 1ns/1ps
interface rqn_if;
    logic start_rotate_mq;
    logic start_rotate_acc;
    logic start_normalize;
    logic gated_clock_pulse;
    logic load_mq;
    logic load_acc;
    logic load_count;
    logic [rqn_pkg::ACC_W-1:0] load_data;
    logic shift_wait;
    logic sequence_resume;
    logic shift_done;
    logic [rqn_pkg::MQ_W-1:0] mq_value;
    logic [rqn_pkg::ACC_W-1:0] acc_value;
    logic [rqn_pkg::CNT_W-1:0] count_value;

    modport ctl (
        output start_rotate_mq,
        output start_rotate_acc,
        output start_normalize,
        output gated_clock_pulse,
        output load_mq,
        output load_acc,
        output load_count,
        output load_data,
        input shift_wait,
        input sequence_resume,
        input shift_done,
        input mq_value,
        input acc_value,
        input count_value
    );

    modport dev (
        input start_rotate_mq,
        input start_rotate_acc,
        input start_normalize,
        input gated_clock_pulse,
        input load_mq,
        input load_acc,
        input load_count,
        input load_data,
        output shift_wait,
        output sequence_resume,
        output shift_done,
        output mq_value,
        output acc_value,
        output count_value
    );
endinterface : rqn_if

// file: hdl/rqn_shift_counter.sv
// Down-counting shift counter with load and zero, one and 38 detection
`timescale 1ns/1ps
module rqn_shift_counter (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic load_en,
    input wire logic [rqn_pkg::CNT_W-1:0] load_value,
    input wire logic dec_en,
    output logic [rqn_pkg::CNT_W-1:0] count,
    output logic is_zero,
    output logic is_one,
    output logic is_38
);

    logic [rqn_pkg::CNT_W-1:0] count_q;

    // Load wins over decrement; callers never ask for both
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_q <= rqn_pkg::CNT_ZERO;
        end else if (load_en) begin
            count_q <= load_value;
        end else if (dec_en) begin
            count_q <= count_q - rqn_pkg::CNT_ONE;
        end
    end

    assign count = count_q;
    assign is_zero = (count_q == rqn_pkg::CNT_ZERO);
    assign is_one = (count_q == rqn_pkg::CNT_ONE);
    assign is_38 = (count_q == rqn_pkg::CNT_38);

endmodule : rqn_shift_counter

// file: hdl/rqn_device.sv
// Sequencer device: MQ rotate, accumulator rotate and normalize on gated pulses
`timescale 1ns/1ps
module rqn_device (
    input wire logic core_clk,
    input wire logic sys_rst,
    rqn_if.dev bus,
    output logic mq_rotating,
    output logic acc_rotating,
    output logic normalizing
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    logic rot_mq_q;
    logic rot_acc_q;
    logic norm_q;
    logic wait_q;
    logic resume_q;
    logic done_q;
    logic [rqn_pkg::MQ_W-1:0] mq_q;
    logic [rqn_pkg::ACC_W-1:0] acc_q;

    logic [rqn_pkg::CNT_W-1:0] cnt;
    logic cnt_zero;
    logic cnt_one;
    logic cnt_38;

    ////////////////////////////////////////////////////////////////////////////
    // Decode of starts and pulses

    logic idle;
    logic start_mq_ok;
    logic start_acc_ok;
    logic start_norm_ok;
    logic step_rot;
    logic step_norm;
    logic bits_equal;
    logic rot_last;
    logic norm_end;
    logic norm_wrap;

    // Starts and loads are taken only while nothing runs
    assign idle = !(rot_mq_q || rot_acc_q || norm_q);

    // A zero count gives a rotate start neither a flip-flop nor a wait; a normalize start ignores the count
    assign start_mq_ok = bus.start_rotate_mq && idle && !cnt_zero;
    assign start_acc_ok = bus.start_rotate_acc && idle && !cnt_zero;
    assign start_norm_ok = bus.start_normalize && idle;

    // Pulses reach the logic only through a set in-progress flip-flop
    assign step_rot = bus.gated_clock_pulse && (rot_mq_q || rot_acc_q);
    assign step_norm = bus.gated_clock_pulse && norm_q;

    // Sign and most significant bit compared; one path acts per pulse
    assign bits_equal = (acc_q[rqn_pkg::ACC_SIGN_BIT] == acc_q[rqn_pkg::ACC_MSB_BIT]);

    assign rot_last = step_rot && cnt_one;
    // Difference ends it, or the 38 count with sign still unbroken
    assign norm_end = step_norm && (!bits_equal || cnt_38);
    // After 36 equal tests the count is zero; reload so shifting goes on
    assign norm_wrap = step_norm && bits_equal && cnt_zero;

    ////////////////////////////////////////////////////////////////////////////
    // Shift counter

    logic cnt_load;
    logic [rqn_pkg::CNT_W-1:0] cnt_load_value;
    logic cnt_dec;

    always_comb begin
        cnt_load = 1'b0;
        cnt_load_value = bus.load_data[rqn_pkg::CNT_W-1:0];
        if (start_norm_ok) begin
            cnt_load = 1'b1;
            cnt_load_value = rqn_pkg::CNT_36;
        end else if (norm_wrap) begin
            cnt_load = 1'b1;
            cnt_load_value = rqn_pkg::CNT_71;
        end else if (bus.load_count && idle) begin
            cnt_load = 1'b1;
        end
    end

    // Decrement on every rotate step and on equal normalize steps at a nonzero count
    assign cnt_dec = step_rot || (step_norm && bits_equal && !cnt_zero);

    rqn_shift_counter u_shift_counter (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .load_en(cnt_load),
        .load_value(cnt_load_value),
        .dec_en(cnt_dec),
        .count(cnt),
        .is_zero(cnt_zero),
        .is_one(cnt_one),
        .is_38(cnt_38)
    );

    ////////////////////////////////////////////////////////////////////////////
    // In-progress flip-flops

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rot_mq_q <= 1'b0;
        end else if (start_mq_ok) begin
            rot_mq_q <= 1'b1;
        end else if (rot_last) begin
            rot_mq_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rot_acc_q <= 1'b0;
        end else if (start_acc_ok) begin
            rot_acc_q <= 1'b1;
        end else if (rot_last) begin
            rot_acc_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            norm_q <= 1'b0;
        end else if (start_norm_ok) begin
            norm_q <= 1'b1;
        end else if (norm_end) begin
            norm_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Handshake with the central timing control

    // Wait stands from an accepted start until the sequence ends
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wait_q <= 1'b0;
        end else if (start_mq_ok || start_acc_ok || start_norm_ok) begin
            wait_q <= 1'b1;
        end else if (rot_last || norm_end) begin
            wait_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            resume_q <= 1'b0;
        end else begin
            resume_q <= rot_last || norm_end;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            done_q <= 1'b0;
        end else begin
            done_q <= rot_last;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data registers

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mq_q <= rqn_pkg::MQ_RESET;
        end else if (step_rot && rot_mq_q) begin
            mq_q <= {mq_q[rqn_pkg::MQ_W-2:0], mq_q[rqn_pkg::MQ_W-1]};
        end else if (bus.load_mq && idle) begin
            mq_q <= bus.load_data[rqn_pkg::MQ_W-1:0];
        end
    end

    // Equal bits rotate; differing bits leave the word as the result
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_q <= rqn_pkg::ACC_RESET;
        end else if ((step_rot && rot_acc_q) || (step_norm && bits_equal)) begin
            acc_q <= {acc_q[rqn_pkg::ACC_W-2:0], acc_q[rqn_pkg::ACC_W-1]};
        end else if (bus.load_acc && idle) begin
            acc_q <= bus.load_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign bus.shift_wait = wait_q;
    assign bus.sequence_resume = resume_q;
    assign bus.shift_done = done_q;
    assign bus.mq_value = mq_q;
    assign bus.acc_value = acc_q;
    assign bus.count_value = cnt;
    assign mq_rotating = rot_mq_q;
    assign acc_rotating = rot_acc_q;
    assign normalizing = norm_q;

endmodule : rqn_device

// file: hdl/rqn_controller.sv
// Central timing control end: register port, command sequencing, pulse gating
`timescale 1ns/1ps
module rqn_controller (
    input wire logic core_clk,
    input wire logic sys_rst,
    rqn_if.ctl bus,
    input wire logic [rqn_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [rqn_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [rqn_pkg::DATA_W-1:0] reg_rdata
);

    rqn_pkg::rqn_ctl_state_type state_q;
    rqn_pkg::rqn_kind_type kind_q;
    logic start_mq_q;
    logic start_acc_q;
    logic start_norm_q;
    logic pulse_q;
    logic ld_mq_q;
    logic ld_acc_q;
    logic ld_count_q;
    logic [rqn_pkg::ACC_W-1:0] ld_data_q;
    logic [rqn_pkg::DATA_W-1:0] acc_lo_q;
    logic [rqn_pkg::DATA_W-1:0] rdata_q;
    logic busy;

    assign busy = (state_q != rqn_pkg::CTL_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // Sequencing

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= rqn_pkg::CTL_IDLE;
            kind_q <= rqn_pkg::KIND_ROT_MQ;
            start_mq_q <= 1'b0;
            start_acc_q <= 1'b0;
            start_norm_q <= 1'b0;
            pulse_q <= 1'b0;
        end else begin
            start_mq_q <= 1'b0;
            start_acc_q <= 1'b0;
            start_norm_q <= 1'b0;
            unique case (state_q)
                rqn_pkg::CTL_IDLE: begin
                    if (reg_wr && reg_addr == rqn_pkg::REG_CMD) begin
                        if (reg_wdata == rqn_pkg::CMD_ROTATE_MQ) begin
                            kind_q <= rqn_pkg::KIND_ROT_MQ;
                            state_q <= rqn_pkg::CTL_START;
                        end else if (reg_wdata == rqn_pkg::CMD_NORMALIZE) begin
                            // Prerotation by 36 comes first; count loaded below
                            kind_q <= rqn_pkg::KIND_ROT_ACC;
                            state_q <= rqn_pkg::CTL_START;
                        end
                    end
                end
                rqn_pkg::CTL_START: begin
                    start_mq_q <= (kind_q == rqn_pkg::KIND_ROT_MQ);
                    start_acc_q <= (kind_q == rqn_pkg::KIND_ROT_ACC);
                    start_norm_q <= (kind_q == rqn_pkg::KIND_NORM);
                    state_q <= rqn_pkg::CTL_CHECK;
                end
                rqn_pkg::CTL_CHECK: begin
                    // Gives the device one edge to raise its wait
                    state_q <= rqn_pkg::CTL_RUN;
                end
                rqn_pkg::CTL_RUN: begin
                    if (bus.sequence_resume || !bus.shift_wait) begin
                        pulse_q <= 1'b0;
                        if (kind_q == rqn_pkg::KIND_ROT_ACC) begin
                            kind_q <= rqn_pkg::KIND_NORM;
                            state_q <= rqn_pkg::CTL_START;
                        end else begin
                            state_q <= rqn_pkg::CTL_IDLE;
                        end
                    end else begin
                        // One pulse may trail the end; the device ignores it
                        pulse_q <= 1'b1;
                    end
                end
                default: begin
                    state_q <= rqn_pkg::CTL_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Loads into the device

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ld_mq_q <= 1'b0;
            ld_acc_q <= 1'b0;
            ld_count_q <= 1'b0;
            ld_data_q <= rqn_pkg::ACC_RESET;
            acc_lo_q <= rqn_pkg::DATA_ZERO;
        end else begin
            ld_mq_q <= 1'b0;
            ld_acc_q <= 1'b0;
            ld_count_q <= 1'b0;
            if (!busy && reg_wr) begin
                if (reg_addr == rqn_pkg::REG_CMD && reg_wdata == rqn_pkg::CMD_NORMALIZE) begin
                    ld_count_q <= 1'b1;
                    ld_data_q <= {{(rqn_pkg::ACC_W-rqn_pkg::CNT_W){1'b0}}, rqn_pkg::CNT_36};
                end else if (reg_addr == rqn_pkg::REG_COUNT) begin
                    ld_count_q <= 1'b1;
                    ld_data_q <= {rqn_pkg::DATA_ZERO, reg_wdata};
                end else if (reg_addr == rqn_pkg::REG_MQ) begin
                    ld_mq_q <= 1'b1;
                    ld_data_q <= {rqn_pkg::DATA_ZERO, reg_wdata};
                end else if (reg_addr == rqn_pkg::REG_ACC_LO) begin
                    acc_lo_q <= reg_wdata;
                end else if (reg_addr == rqn_pkg::REG_ACC_HI) begin
                    ld_acc_q <= 1'b1;
                    ld_data_q <= {reg_wdata, acc_lo_q};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= rqn_pkg::DATA_ZERO;
        end else if (reg_rd) begin
            unique case (reg_addr)
                rqn_pkg::REG_COUNT: rdata_q <= {29'h0000_0000, bus.count_value};
                rqn_pkg::REG_MQ: rdata_q <= bus.mq_value;
                rqn_pkg::REG_ACC_LO: rdata_q <= bus.acc_value[rqn_pkg::DATA_W-1:0];
                rqn_pkg::REG_ACC_HI: rdata_q <= bus.acc_value[rqn_pkg::ACC_W-1:rqn_pkg::DATA_W];
                rqn_pkg::REG_STATUS: rdata_q <= {34'h0_0000_0000, bus.shift_wait, busy};
                default: rdata_q <= rqn_pkg::DATA_ZERO;
            endcase
        end else begin
            rdata_q <= rqn_pkg::DATA_ZERO;
        end
    end

    assign reg_rdata = rdata_q;
    assign bus.start_rotate_mq = start_mq_q;
    assign bus.start_rotate_acc = start_acc_q;
    assign bus.start_normalize = start_norm_q;
    assign bus.gated_clock_pulse = pulse_q;
    assign bus.load_mq = ld_mq_q;
    assign bus.load_acc = ld_acc_q;
    assign bus.load_count = ld_count_q;
    assign bus.load_data = ld_data_q;

endmodule : rqn_controller

// file: tb/rqn_monitor.sv
// Checker of the link between the timing control end and the sequencer device
`timescale 1ns/1ps
module rqn_monitor (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic start_rotate_mq,
    input wire logic start_normalize,
    input wire logic gated_clock_pulse,
    input wire logic load_mq,
    input wire logic load_acc,
    input wire logic load_count,
    input wire logic shift_wait,
    input wire logic sequence_resume,
    input wire logic shift_done,
    input wire logic [rqn_pkg::MQ_W-1:0] mq_value,
    input wire logic [rqn_pkg::ACC_W-1:0] acc_value,
    input wire logic [rqn_pkg::CNT_W-1:0] count_value
);
    default clocking mon_cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    logic mq_run_q;
    logic norm_run_q;
    logic step;
    logic same;
    logic idle_pulse;
    logic [rqn_pkg::MQ_W-1:0] mq_rot;
    logic [rqn_pkg::ACC_W-1:0] acc_rot;
    assign step = shift_wait && gated_clock_pulse;
    assign same = acc_value[34] == acc_value[35];
    assign mq_rot = {mq_value[34:0], mq_value[35]};
    assign acc_rot = {acc_value[70:0], acc_value[71]};
    assign idle_pulse = !shift_wait && gated_clock_pulse && !load_mq && !load_acc
        && !load_count && !start_normalize;

    ////////////////////////////////////////////////////////////////////////////
    // Which sequence runs is not on the link, so it is tracked from accepted starts
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mq_run_q <= 1'b0;
        end else if (start_rotate_mq && !shift_wait && count_value != 7'h00) begin
            mq_run_q <= 1'b1;
        end else if (sequence_resume) begin
            mq_run_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            norm_run_q <= 1'b0;
        end else if (start_normalize && !shift_wait) begin
            norm_run_q <= 1'b1;
        end else if (sequence_resume) begin
            norm_run_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_mq_step;
        mq_run_q && step |=> mq_value == $past(mq_rot) && count_value == $past(count_value) - 7'h01;
    endproperty
    a_mq_step: assert property (p_mq_step) else $error("MQ step wrong");

    property p_mq_end;
        mq_run_q && step && count_value == 7'h01 |=> sequence_resume && shift_done && !shift_wait;
    endproperty
    a_mq_end: assert property (p_mq_end) else $error("MQ end wrong");

    property p_zero_start;
        start_rotate_mq && !shift_wait && count_value == 7'h00
            |=> (!shift_wait && $stable(mq_value)) [*4];
    endproperty
    a_zero_start: assert property (p_zero_start) else $error("zero count acted");

    property p_wait_start;
        start_rotate_mq && !shift_wait && count_value != 7'h00 |=> shift_wait;
    endproperty
    a_wait_start: assert property (p_wait_start) else $error("no wait at start");

    property p_norm_start;
        start_normalize && !shift_wait |=> shift_wait && count_value == 7'h24;
    endproperty
    a_norm_start: assert property (p_norm_start) else $error("normalize start wrong");

    property p_norm_eq;
        norm_run_q && step && same && count_value != 7'h00
            |=> acc_value == $past(acc_rot) && count_value == $past(count_value) - 7'h01;
    endproperty
    a_norm_eq: assert property (p_norm_eq) else $error("equal step wrong");

    property p_norm_wrap;
        norm_run_q && step && same && count_value == 7'h00
            |=> acc_value == $past(acc_rot) && count_value == 7'h47;
    endproperty
    a_norm_wrap: assert property (p_norm_wrap) else $error("wrap to 71 wrong");

    property p_norm_diff;
        norm_run_q && step && !same
            |=> sequence_resume && !shift_wait && $stable(acc_value) && $stable(count_value);
    endproperty
    a_norm_diff: assert property (p_norm_diff) else $error("differ end wrong");

    property p_norm_38;
        norm_run_q && step && same && count_value == 7'h26
            |=> sequence_resume && !shift_wait && count_value == 7'h25;
    endproperty
    a_norm_38: assert property (p_norm_38) else $error("end at 38 wrong");

    property p_idle;
        idle_pulse |=> $stable(mq_value) && $stable(acc_value) && $stable(count_value);
    endproperty
    a_idle: assert property (p_idle) else $error("idle pulse acted");

    c_mq_end: cover property (mq_run_q && sequence_resume);
    c_norm_diff: cover property (norm_run_q && step && !same);
    c_norm_38: cover property (norm_run_q && step && same && count_value == 7'h26);
endmodule : rqn_monitor

// file: tb/test_rotate_q_and_normalize_seq.sv
// Self-checking bench for the controller and device pair of the sequencer
`timescale 1ns/1ps
module test_rotate_q_and_normalize_seq;
    logic core_clk;
    logic sys_rst;
    logic [rqn_pkg::ADDR_W-1:0] reg_addr;
    logic [rqn_pkg::DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [rqn_pkg::DATA_W-1:0] reg_rdata;
    logic mq_rotating;
    logic acc_rotating;
    logic normalizing;
    int bad_count;
    int total_checks;
    logic [35:0] rd_val;
    logic [71:0] norm_in [6];
    logic [71:0] exp_acc;
    logic [6:0] exp_cnt;
    int rot_cnt [4];

    rqn_if rqn_if_i ();
    rqn_device rqn_device_i (.core_clk(core_clk), .sys_rst(sys_rst), .bus(rqn_if_i),
        .mq_rotating(mq_rotating), .acc_rotating(acc_rotating), .normalizing(normalizing));
    rqn_controller rqn_controller_i (.core_clk(core_clk), .sys_rst(sys_rst), .bus(rqn_if_i),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    rqn_monitor rqn_monitor_i (.core_clk(core_clk), .sys_rst(sys_rst),
        .start_rotate_mq(rqn_if_i.start_rotate_mq), .start_normalize(rqn_if_i.start_normalize),
        .gated_clock_pulse(rqn_if_i.gated_clock_pulse), .load_mq(rqn_if_i.load_mq),
        .load_acc(rqn_if_i.load_acc), .load_count(rqn_if_i.load_count),
        .shift_wait(rqn_if_i.shift_wait), .sequence_resume(rqn_if_i.sequence_resume),
        .shift_done(rqn_if_i.shift_done), .mq_value(rqn_if_i.mq_value),
        .acc_value(rqn_if_i.acc_value), .count_value(rqn_if_i.count_value));

    ////////////////////////////////////////////////////////////////////////////
    task automatic reg_write(input logic [3:0] a, input logic [35:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [3:0] a, output logic [35:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask : reg_read

    task automatic check(input string name, input logic [71:0] exp, input logic [71:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // Bounded poll so a stuck sequence shows as a mismatch rather than a hang
    task automatic wait_idle();
        logic [35:0] s;
        int n;
        s = 36'h0_0000_0001;
        n = 0;
        repeat (2) @(posedge core_clk);
        while (s[0] !== 1'b0 && n < 400) begin
            reg_read(rqn_pkg::REG_STATUS, s);
            n++;
        end
        check("busy", 72'h00_0000_0000_0000_0000, {71'h0, s[0]});
    endtask : wait_idle

    task automatic final_report();
        if (bad_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    function automatic logic [35:0] rotl_mq(input logic [35:0] v, input int k);
        return (v << k) | (v >> (36 - k));
    endfunction : rotl_mq

    // Prerotation by 36, then compare and rotate as the sequencer should
    function automatic logic [78:0] norm_model(input logic [71:0] a);
        logic [6:0] k;
        bit fin;
        a = {a[35:0], a[71:36]};
        k = 7'h24;
        fin = 1'b0;
        while (!fin) begin
            if (a[34] != a[35]) begin
                fin = 1'b1;
            end else begin
                a = {a[70:0], a[71]};
                if (k == 7'h00) begin
                    k = 7'h47;
                end else begin
                    fin = (k == 7'h26);
                    k = k - 7'h01;
                end
            end
        end
        return {k, a};
    endfunction : norm_model

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    initial begin
        #2000000;
        bad_count++;
        final_report();
    end

    initial begin
        sys_rst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 36'h0_0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        bad_count = 0;
        total_checks = 0;
        rot_cnt = '{0, 1, 5, 36};
        norm_in = '{72'h00_0000_0000_0000_0000, 72'hFF_FFFF_FFFF_FFFF_FFFF,
            72'h40_0000_0000_0000_0000, 72'h00_0000_0004_0000_0000,
            72'hFF_FFFF_F000_0000_1234, 72'h00_0000_0000_0000_0001};
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        reg_read(4'hF, rd_val);
        check("unmapped", 72'h00_0000_0000_0000_0000, {36'h0, rd_val});
        foreach (rot_cnt[i]) begin
            reg_write(rqn_pkg::REG_MQ, 36'h8_1234_5671);
            reg_write(rqn_pkg::REG_COUNT, 36'(rot_cnt[i]));
            reg_write(rqn_pkg::REG_CMD, rqn_pkg::CMD_ROTATE_MQ);
            // A load while busy must be dropped, not land mid-rotation
            if (rot_cnt[i] != 0) begin
                reg_write(rqn_pkg::REG_MQ, rqn_pkg::DATA_ZERO);
                @(negedge core_clk);
                check("mq_rotating", 72'h1, {71'h0, mq_rotating});
            end
            wait_idle();
            reg_read(rqn_pkg::REG_MQ, rd_val);
            check("mq", {36'h0, rotl_mq(36'h8_1234_5671, rot_cnt[i])}, {36'h0, rd_val});
            reg_read(rqn_pkg::REG_COUNT, rd_val);
            check("count", 72'h00_0000_0000_0000_0000, {36'h0, rd_val});
        end
        foreach (norm_in[i]) begin
            reg_write(rqn_pkg::REG_ACC_LO, norm_in[i][35:0]);
            reg_write(rqn_pkg::REG_ACC_HI, norm_in[i][71:36]);
            reg_write(rqn_pkg::REG_CMD, rqn_pkg::CMD_NORMALIZE);
            repeat (3) @(negedge core_clk);
            check("acc_rotating", 72'h1, {71'h0, acc_rotating});
            repeat (40) @(negedge core_clk);
            check("normalizing", 72'h1, {71'h0, normalizing});
            wait_idle();
            {exp_cnt, exp_acc} = norm_model(norm_in[i]);
            reg_read(rqn_pkg::REG_ACC_LO, rd_val);
            check("acc_lo", {36'h0, exp_acc[35:0]}, {36'h0, rd_val});
            reg_read(rqn_pkg::REG_ACC_HI, rd_val);
            check("acc_hi", {36'h0, exp_acc[71:36]}, {36'h0, rd_val});
            reg_read(rqn_pkg::REG_COUNT, rd_val);
            check("index", {65'h0, exp_cnt}, {36'h0, rd_val});
        end
        final_report();
    end
endmodule : test_rotate_q_and_normalize_seq
